// ### logic/mfsf_pkg.sv
`default_nettype none
package mfsf_pkg;
    // ==========================================================
    // Register map.
    localparam logic [7:0] MFSF_ADDR_PRIMARY = 8'h41;
    localparam logic [7:0] MFSF_ADDR_SECONDARY = 8'h42;
    localparam logic [7:0] MFSF_RESET_VALUE = 8'h00;
    // ==========================================================
    // Field positions, primary register.
    localparam int MFSF_P_V25 = 0;
    localparam int MFSF_P_CORE = 1;
    localparam int MFSF_P_V33 = 2;
    localparam int MFSF_P_V5 = 3;
    localparam int MFSF_P_ZONE1 = 4;
    localparam int MFSF_P_ZONE2 = 5;
    localparam int MFSF_P_ZONE3 = 6;
    localparam int MFSF_P_SUMMARY = 7;
    // Field positions, secondary register.
    localparam int MFSF_S_V12 = 0;
    localparam int MFSF_S_RSVD = 1;
    localparam int MFSF_S_FAN_LO = 2;
    localparam int MFSF_S_DIODE1 = 6;
    localparam int MFSF_S_DIODE2 = 7;
    // ==========================================================
    // Channel counts.
    localparam int MFSF_NUM_VOLT = 5;
    localparam int MFSF_NUM_FAN = 4;
    localparam int MFSF_NUM_ZONE = 3;
endpackage
`default_nettype wire

// ### logic/mfsf_flag_if.sv
`default_nettype none
// Carries live fault conditions and strobe-gated fault sets into the flag store.
interface mfsf_flag_if;
    logic [7:0] primary_set;
    logic [7:0] primary_live;
    logic [7:0] secondary_set;
    logic [7:0] secondary_live;
    modport src (output primary_set, output primary_live, output secondary_set, output secondary_live);
    modport dst (input primary_set, input primary_live, input secondary_set, input secondary_live);
endinterface
`default_nettype wire

// ### logic/mfsf_flag_store.sv
`default_nettype none
// Two 8-bit sticky flag registers with clear-on-read of vanished faults.
module mfsf_flag_store
    import mfsf_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    mfsf_flag_if.dst flags,
    input wire logic clr_primary,
    input wire logic clr_secondary,
    output logic [7:0] primary_r,
    output logic [7:0] secondary_r
);
    logic [7:0] sec_nxt;

    // ==========================================================
    // Secondary register; reserved bit forced to zero.
    always_comb begin
        sec_nxt = clr_secondary ? (secondary_r & flags.secondary_live) : secondary_r;
        sec_nxt = sec_nxt | flags.secondary_set;
        sec_nxt[MFSF_S_RSVD] = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            secondary_r <= MFSF_RESET_VALUE;
        end else begin
            secondary_r <= sec_nxt;
        end
    end

    // ==========================================================
    // Primary register; set wins over the clear so no event is lost.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            primary_r <= MFSF_RESET_VALUE;
        end else begin
            primary_r <= (clr_primary ? (primary_r & flags.primary_live) : primary_r) | flags.primary_set;
        end
    end
endmodule
`default_nettype wire

// ### logic/mfsf_status.sv
`default_nettype none
module mfsf_status
    import mfsf_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [39:0] volt_reading,
    input wire logic [39:0] volt_low_limit,
    input wire logic [39:0] volt_high_limit,
    input wire logic [4:0] volt_done,
    input wire logic [23:0] temp_reading,
    input wire logic [23:0] temp_low_limit,
    input wire logic [23:0] temp_high_limit,
    input wire logic [2:0] temp_done,
    input wire logic [63:0] tacho_reading,
    input wire logic [63:0] tacho_min_limit,
    input wire logic [3:0] tacho_done,
    input wire logic remote_diode_one_fault,
    input wire logic remote_diode_two_fault,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read_done,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata
);
    mfsf_flag_if fl();
    logic [7:0] primary_r;
    logic [7:0] secondary_r;
    wire logic [3:0] volt_fault;
    wire logic [2:0] zone_fault;
    wire logic [3:0] fan_fault;
    logic v12_fault;
    logic zone_one_temp_flag;
    logic zone_two_temp_flag;
    logic zone_three_temp_flag;
    logic secondary_any;
    logic clr_primary_hit;
    logic clr_secondary_hit;
    logic [7:0] rdata_nxt;
    logic unused_write;

    // ==========================================================
    // Overview.
    // Each flag is a sticky bit: a fault reported on an edge sets it, and only a completed
    // host read of its register can drop it again, and then only if the fault has gone.
    // Faults that still stand when the read finishes stay set, so software that clears
    // and re-reads sees a persistent fault twice rather than losing it.
    // The block has no write path of its own; limits and readings arrive ready-made from
    // the measurement logic, and this block only compares, latches and reports.

    // ==========================================================
    // Lane map of the packed measurement buses.
    // Supply lanes are eight bits each: lane 0 is the 2.5V input, lane 1 the core supply,
    // lane 2 the 3.3V input, lane 3 the 5V input and lane 4 the 12V input.
    // Temperature lanes are eight-bit signed values: lane 0 is remote diode one against the
    // zone one window, lane 1 the die sensor against zone two, and lane 2 remote diode two
    // against zone three.
    // Tachometer lanes are sixteen bits wide, fan one in lane 0; a longer period means a
    // slower fan, so a reading above the minimum-speed limit marks a stall.
    // Each done bit pulses for one cycle when the matching result is stored; a window
    // compare only sets its flag in that cycle, so a stale reading left on the bus between
    // conversions cannot raise a flag on its own.
    // The diode fault inputs are levels from the analogue front end and set their flags
    // on every edge while they stand.

    // ==========================================================
    // Helper functions.
    // Window test shared by supplies 0..3: the low limit is inclusive, so a reading that
    // sits exactly on its low limit already counts as a fault.
    function automatic logic win_incl(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v <= lo) || (v > hi);
    endfunction

    // Address decode, shared by both clear strobes so that they always agree with the
    // read mux on which register a host access touches.
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ==========================================================
    // Channel compares.
    // Zone order: 0 = diode one, 1 = die, 2 = diode two; diode-two low compare uses its own
    // zone limit since the shared-limit wording reads as a slip.
    // Supplies and fans are unsigned codes while temperatures are signed; an unsigned
    // compare would turn a reading below zero into a large code and miss a cold fault.
    genvar g;
    generate
        for (g = 0; g < MFSF_NUM_VOLT - 1; g++) begin : g_volt
            assign volt_fault[g] = win_incl(volt_reading[g*8 +: 8], volt_low_limit[g*8 +: 8],
                                            volt_high_limit[g*8 +: 8]);
        end
        for (g = 0; g < MFSF_NUM_ZONE; g++) begin : g_zone
            assign zone_fault[g] = ($signed(temp_reading[g*8 +: 8]) <= $signed(temp_low_limit[g*8 +: 8])) ||
                                   ($signed(temp_reading[g*8 +: 8]) > $signed(temp_high_limit[g*8 +: 8]));
        end
        for (g = 0; g < MFSF_NUM_FAN; g++) begin : g_fan
            assign fan_fault[g] = tacho_reading[g*16 +: 16] > tacho_min_limit[g*16 +: 16];
        end
    endgenerate

    // The 12V window is strict at both ends, unlike the other supplies.
    assign v12_fault = (volt_reading[39:32] < volt_low_limit[39:32]) ||
                       (volt_reading[39:32] > volt_high_limit[39:32]);

    // ==========================================================
    // Zone flags fold in the diode faults.
    // An open or shorted diode gives a meaningless reading, so its zone is flagged
    // whatever the compare says.
    assign zone_one_temp_flag = zone_fault[0] || remote_diode_one_fault;
    assign zone_two_temp_flag = zone_fault[1];
    assign zone_three_temp_flag = zone_fault[2] || remote_diode_two_fault;

    // ==========================================================
    // Secondary conditions; a diode fault is always live, not strobed.
    // The live vector says which faults still stand and so decides what a read may clear;
    // the set vector says which faults are being reported on this edge.
    always_comb begin
        fl.secondary_live = 8'h00;
        fl.secondary_live[MFSF_S_V12] = v12_fault;
        fl.secondary_live[MFSF_S_FAN_LO +: 4] = fan_fault;
        fl.secondary_live[MFSF_S_DIODE1] = remote_diode_one_fault;
        fl.secondary_live[MFSF_S_DIODE2] = remote_diode_two_fault;
        fl.secondary_set = 8'h00;
        fl.secondary_set[MFSF_S_V12] = v12_fault && volt_done[4];
        fl.secondary_set[MFSF_S_FAN_LO +: 4] = fan_fault & tacho_done;
        fl.secondary_set[MFSF_S_DIODE1] = remote_diode_one_fault;
        fl.secondary_set[MFSF_S_DIODE2] = remote_diode_two_fault;
    end

    // Summary of the secondary register: content already held or set on this edge.
    // Looking at the pending sets too keeps bit seven from lagging the first secondary
    // fault by a cycle, so a host that reads the primary register first never misses it.
    assign secondary_any = |(secondary_r | fl.secondary_set);

    // ==========================================================
    // Primary conditions, one line per field.
    // The summary bit is both set and kept live by the secondary content, so a primary
    // read can only drop it once the secondary register itself has been emptied.
    always_comb begin
        fl.primary_live = 8'h00;
        fl.primary_live[MFSF_P_V25] = volt_fault[0];
        fl.primary_live[MFSF_P_CORE] = volt_fault[1];
        fl.primary_live[MFSF_P_V33] = volt_fault[2];
        fl.primary_live[MFSF_P_V5] = volt_fault[3];
        fl.primary_live[MFSF_P_ZONE1] = zone_one_temp_flag;
        fl.primary_live[MFSF_P_ZONE2] = zone_two_temp_flag;
        fl.primary_live[MFSF_P_ZONE3] = zone_three_temp_flag;
        fl.primary_live[MFSF_P_SUMMARY] = secondary_any;
        fl.primary_set = 8'h00;
        fl.primary_set[MFSF_P_V25] = volt_fault[0] && volt_done[0];
        fl.primary_set[MFSF_P_CORE] = volt_fault[1] && volt_done[1];
        fl.primary_set[MFSF_P_V33] = volt_fault[2] && volt_done[2];
        fl.primary_set[MFSF_P_V5] = volt_fault[3] && volt_done[3];
        fl.primary_set[MFSF_P_ZONE1] = (zone_fault[0] && temp_done[0]) || remote_diode_one_fault;
        fl.primary_set[MFSF_P_ZONE2] = zone_fault[1] && temp_done[1];
        fl.primary_set[MFSF_P_ZONE3] = (zone_fault[2] && temp_done[2]) || remote_diode_two_fault;
        fl.primary_set[MFSF_P_SUMMARY] = secondary_any;
    end

    // ==========================================================
    // Clear strobes. The host side pulses reg_read_done only once the last bit of the
    // byte has left the device, yet a flag set on the edge that loaded the byte can drop
    // unreported if its fault has gone; an event landing in the clear cycle itself is kept because the store lets a set win over
    // the clear.
    assign clr_primary_hit = reg_read_done && addr_is(reg_addr, MFSF_ADDR_PRIMARY);
    assign clr_secondary_hit = reg_read_done && addr_is(reg_addr, MFSF_ADDR_SECONDARY);

    // ==========================================================
    // Sticky store; set wins over clear in the same cycle.
    mfsf_flag_store u_store (
        .clock(clock),
        .resetn(resetn),
        .flags(fl),
        .clr_primary(clr_primary_hit),
        .clr_secondary(clr_secondary_hit),
        .primary_r(primary_r),
        .secondary_r(secondary_r)
    );

    // ==========================================================
    // Read mux. Addresses outside this block read as zero, so the mux can sit on a
    // shared read bus without a separate select.
    always_comb begin
        unique case (reg_addr)
            MFSF_ADDR_PRIMARY: rdata_nxt = primary_r;
            MFSF_ADDR_SECONDARY: rdata_nxt = secondary_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data are registered, so reg_rdata shows the register addressed one edge earlier.
    // A flag set on that same edge shows on the next read instead, unless its fault has gone
    // by the edge where this read's clear lands, which then drops it unreported.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= MFSF_RESET_VALUE;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // Write path. Both status registers are read only, so a write strobe and its data are
    // accepted by the bus and then dropped here; nothing but a fault or a completed read
    // can change a flag. The unused inputs are folded into one sink so they stay visibly
    // consumed rather than dangling.
    assign unused_write = reg_write ^ (|reg_wdata);
endmodule
`default_nettype wire

// ### tb/mfsf_status_monitor.sv
`default_nettype none
// ====
// Port checks of the sticky fault flags.
module mfsf_status_monitor
    import mfsf_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic remote_diode_one_fault,
    input wire logic remote_diode_two_fault,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read_done,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pri;
    logic sec;
    // Read data lags the address by one edge, so each check looks one edge later.
    assign pri = reg_addr == MFSF_ADDR_PRIMARY;
    assign sec = reg_addr == MFSF_ADDR_SECONDARY;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence cause(f, a);
        f ##1 a;
    endsequence
    sequence unread(a);
        a && !reg_read_done ##1 a;
    endsequence
    a_reset_zero: assert property (disable iff (1'b0) !resetn |=> reg_rdata == 8'h00)
        else $error("read data not zero after reset");
    a_reserved_zero: assert property (sec |=> !reg_rdata[1])
        else $error("reserved bit set");
    a_one_zone: assert property (cause(remote_diode_one_fault, pri) |=> reg_rdata[4])
        else $error("zone one bit missing");
    a_one_sec: assert property (cause(remote_diode_one_fault, sec) |=> reg_rdata[6])
        else $error("diode one bit missing");
    a_two_zone: assert property (cause(remote_diode_two_fault, pri) |=> reg_rdata[6])
        else $error("zone three bit missing");
    a_two_sec: assert property (cause(remote_diode_two_fault, sec) |=> reg_rdata[7])
        else $error("diode two bit missing");
    a_hold_pri: assert property (unread(pri) |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata))
        else $error("primary flag lost unread");
    a_hold_sec: assert property (unread(sec) |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata))
        else $error("secondary flag lost unread");
    a_summary_bit: assert property (sec ##1 (pri && reg_rdata != 8'h00) |=> reg_rdata[7])
        else $error("summary bit missing");
endmodule
bind mfsf_status mfsf_status_monitor mon (.clock(clock), .resetn(resetn),
    .remote_diode_one_fault(remote_diode_one_fault), .remote_diode_two_fault(remote_diode_two_fault),
    .reg_addr(reg_addr), .reg_read_done(reg_read_done), .reg_rdata(reg_rdata));
`default_nettype wire

// ### tb/mfsf_host.sv
`default_nettype none
// ====
// Host software reaching the two status registers.
module mfsf_host (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_read_done,
    output logic reg_write,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_read_done, reg_write, reg_wdata} = '0;
    // The byte is taken before it is marked sent, so the clear never races the read.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock) reg_addr = a;
        @(negedge clock) d = reg_rdata;
        reg_read_done = 1'b1;
        @(negedge clock) reg_read_done = 1'b0;
    endtask
    // Writes are offered whole for one edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(negedge clock) reg_write = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_monitor_fault_status_flags.sv
`default_nettype none
// ====
// Random faults against a flag model.
module tb_monitor_fault_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, d1, d2;
    logic [39:0] vr, vl, vh;
    logic [23:0] tr, tl, th;
    logic [63:0] fr, fm;
    logic [4:0] vd;
    logic [2:0] td;
    logic [3:0] fd;
    logic [15:0] seed, c;
    logic [7:0] got;
    logic [319:0] rv;
    wire logic [7:0] addr, wdata, rdata;
    wire logic rd, wr;
    int fail_count, num_checks, mp, ms;
    mfsf_status dut (.clock(clock), .resetn(resetn), .volt_reading(vr), .volt_low_limit(vl),
        .volt_high_limit(vh), .volt_done(vd), .temp_reading(tr), .temp_low_limit(tl), .temp_high_limit(th),
        .temp_done(td), .tacho_reading(fr), .tacho_min_limit(fm), .tacho_done(fd),
        .remote_diode_one_fault(d1), .remote_diode_two_fault(d2), .reg_addr(addr),
        .reg_read_done(rd), .reg_write(wr), .reg_wdata(wdata), .reg_rdata(rdata));
    mfsf_host h (.clock(clock), .reg_rdata(rdata), .reg_addr(addr), .reg_read_done(rd),
        .reg_write(wr), .reg_wdata(wdata));
    // Fault conditions of the present inputs, secondary in the upper byte.
    function automatic logic [15:0] live();
        logic [15:0] x;
        x = {d2, d1, 14'h0000};
        for (int i = 0; i < 4; i++) begin
            x[i] = vr[i*8+:8] <= vl[i*8+:8] || vr[i*8+:8] > vh[i*8+:8];
            x[10+i] = fr[i*16+:16] > fm[i*16+:16];
        end
        x[8] = vr[39:32] < vl[39:32] || vr[39:32] > vh[39:32];
        for (int i = 0; i < 3; i++) begin
            x[4+i] = $signed(tr[i*8+:8]) <= $signed(tl[i*8+:8]) || $signed(tr[i*8+:8]) > $signed(th[i*8+:8]);
        end
        x[4] = x[4] | d1;
        x[6] = x[6] | d2;
        return x;
    endfunction
    // Sixteen-bit maximal-length shift register step.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // New random readings and limits on every lane.
    task automatic scramble();
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            rv[i*16+:16] = seed;
        end
        {vr, vl, vh, tr, tl, th, fr, fm} = rv;
    endtask
    task automatic check(input logic [7:0] a, input logic [7:0] e);
        h.rd(a, got);
        num_checks++;
        if (got !== e) begin
            fail_count++;
            $display("BAD reg %h exp %h got %h", a, e, got);
        end
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        {mp, ms} = '0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // A hang is cut short and counted.
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        stop_test();
    end
    // Flags are set by done strobes, then read with conditions changed; writes must not disturb.
    initial begin
        {fail_count, num_checks, vd, td, fd, d1, d2} = '0;
        seed = 16'hCE99;
        scramble();
        do_reset();
        check(8'h41, 8'h00);
        check(8'h42, 8'h00);
        repeat (30) begin
            @(negedge clock) scramble();
            {d2, d1, vd, td, fd} = {seed[1:0], 12'hFFF};
            c = live();
            {ms, mp} = {ms | c[15:8], mp | c[7:0] | (ms | c[15:8] ? 8'h80 : 8'h00)};
            @(negedge clock) {vd, td, fd} = 12'h000;
            scramble();
            h.wr(8'h41, seed[7:0]);
            h.wr(8'h42, seed[15:8]);
            c = live();
            check(8'h41, mp[7:0]);
            mp = (mp & c[7:0] & 8'h7F) | (ms != 0 ? 8'h80 : 8'h00);
            check(8'h42, ms[7:0]);
            ms = ms & c[15:8];
            check(8'h43, 8'h00);
        end
        {d1, d2} = 2'b00;
        do_reset();
        check(8'h41, 8'h00);
        check(8'h42, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
